// ==== inc/adc_ctrl_pkg.sv ====
// adc_ctrl_pkg: register map, field positions, codes and timing of the adc control block
// assumes a 200 MHz system clock and AXI4-Lite register access with 32-bit data
package adc_ctrl_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_TRIG_REF = 8'h00;  // trigger_and_reference_control
  localparam logic [7:0] OFF_FMT_TIM = 8'h04;   // format_and_timing_control
  localparam logic [7:0] OFF_RES_HI = 8'h08;    // result_high_byte
  localparam logic [7:0] OFF_RES_LO = 8'h0C;    // result_low_byte
  localparam logic [7:0] OFF_CTRL = 8'h10;      // enable and start bits
  localparam logic [7:0] OFF_IRQ_STAT = 8'h14;  // sticky events, cleared by read
  localparam logic [7:0] OFF_IRQ_MASK = 8'h18;  // interrupt mask

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int TRIG_SEL_BIT = 7;
  localparam int PREF_LSB = 2;
  localparam int NREF_LSB = 0;
  localparam int JUSTIFY_BIT = 7;
  localparam int ACQ_LSB = 3;
  localparam int CLKSEL_LSB = 0;
  localparam int ENABLE_BIT = 0;
  localparam int START_BIT = 1;
  localparam logic [7:0] TRIG_REF_WMASK = 8'h8F;
  localparam logic [7:0] FMT_TIM_WMASK = 8'hBF;
  localparam logic [7:0] TRIG_REF_RST = 8'h00;
  localparam logic [7:0] FMT_TIM_RST = 8'h00;
  localparam int EV_DONE = 0;  // conversion finished
  localparam int EV_TRIG = 1;  // special trigger accepted

  // ----------------------------------------------------------------
  // reference select codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PREF_SUPPLY = 2'h0,
    PREF_PIN = 2'h1,
    PREF_FIXED = 2'h2
  } pos_ref_e;
  typedef enum logic {
    NREF_GROUND = 1'h0,
    NREF_PIN = 1'h1
  } neg_ref_e;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int INSTR_NS = 250;  // one instruction cycle at 4 MIPS
  localparam int INSTR_CYC = (INSTR_NS * CLK_MHZ + 999) / 1000;
  localparam int INTOSC_KHZ = 600;  // dedicated conversion oscillator
  localparam int INTOSC_DIV = (CLK_MHZ * 1000) / INTOSC_KHZ;
  localparam int GAP_TAD = 2;  // wait after a conversion
  localparam int CONV_TAD = 11;  // bit periods per conversion
  localparam int RES_BITS = 10;

endpackage : adc_ctrl_pkg

// ==== src/tad_divider.sv ====
// tad_divider: one-cycle enable at the selected conversion-clock rate
// assumes the system clock; the dedicated oscillator is modelled by division
`timescale 1ns/1ps
module tad_divider (
  input wire logic clock,            // system clock
  input wire logic nrst,             // async reset, active low
  input wire logic run,              // count only while high
  input wire logic [2:0] clkSel,     // conversion clock select code
  output logic tadTick               // one-cycle tick per conversion clock period
);
  logic [8:0] cnt_q;
  logic [8:0] lim;

  // divide ratio minus one for each code
  always_comb begin
    case (clkSel)
      3'h0: lim = 9'h001;
      3'h1: lim = 9'h007;
      3'h2: lim = 9'h01F;
      3'h4: lim = 9'h003;
      3'h5: lim = 9'h00F;
      3'h6: lim = 9'h03F;
      default: lim = 9'(adc_ctrl_pkg::INTOSC_DIV - 1);
    endcase
  end

  // free count restarted whenever the converter idles
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 9'h000;
    end else if (!run || cnt_q >= lim) begin
      cnt_q <= 9'h000;
    end else begin
      cnt_q <= cnt_q + 9'h001;
    end
  end

  assign tadTick = run && (cnt_q >= lim);

endmodule : tad_divider

// ==== src/adc_config_and_result_regs.sv ====
// adc_config_and_result_regs: control, sequencing and result registers of a 10-bit adc
// assumes AXI4-Lite master on the system clock; trigger pulses come from same-clock logic
//
// Our own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
module adc_config_and_result_regs (
  input wire logic clock,              // 200 MHz system clock
  input wire logic nrst,               // async reset, active low
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid,      // write address valid
  output logic s_axi_awready,          // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb,  // write strobes
  input wire logic s_axi_wvalid,       // write data valid
  output logic s_axi_wready,           // write data ready
  output logic [1:0] s_axi_bresp,      // write response
  output logic s_axi_bvalid,           // write response valid
  input wire logic s_axi_bready,       // write response ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid,      // read address valid
  output logic s_axi_arready,          // read address ready
  output logic [31:0] s_axi_rdata,     // read data
  output logic [1:0] s_axi_rresp,      // read response
  output logic s_axi_rvalid,           // read data valid
  input wire logic s_axi_rready,       // read data ready
  input wire logic chargeTimeTrig,     // charge_time_unit trigger pulse
  input wire logic captureFiveTrig,    // fifth_capture_compare_unit trigger pulse
  input wire logic [9:0] sarResult,    // conversion_result from the analog core
  output logic holdCapConnect,         // hold_capacitor tied to the channel
  output logic convActive,             // analog core converting
  output logic [1:0] posRefSel,        // positive reference to analog core
  output logic negRefSel,              // negative reference to analog core
  output logic irq                     // level interrupt
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_ACQ = 5'b00010,
    S_DELAY = 5'b00100,
    S_CONV = 5'b01000,
    S_GAP = 5'b10000
  } seq_e;

  seq_e state_q;
  logic [7:0] trigRef_q;
  logic [7:0] fmtTim_q;
  logic [7:0] resHi_q;
  logic [7:0] resLo_q;
  logic enable_q;
  logic start_q;
  logic [1:0] irqStat_q;
  logic [1:0] irqMask_q;
  logic [4:0] tadCnt_q;
  logic [5:0] instCnt_q;
  logic tadTick;
  logic [4:0] acqLen;
  logic useOsc;
  logic trigger_source_select;
  logic trigEv;
  logic doneEv;
  logic swStart;
  logic wrHit;
  logic awPend_q;
  logic wPend_q;
  logic [7:0] awAddr_q;
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;
  logic [31:0] rdVal;

  // ----------------------------------------------------------------
  // conversion clock and decoded fields
  // ----------------------------------------------------------------
  tad_divider u_div (
    .clock(clock),
    .nrst(nrst),
    .run(state_q != S_IDLE),
    .clkSel(fmtTim_q[adc_ctrl_pkg::CLKSEL_LSB +: 3]),
    .tadTick(tadTick)
  );

  assign useOsc = fmtTim_q[1:0] == 2'h3;

  // acquisition length in conversion clock periods
  always_comb begin
    case (fmtTim_q[adc_ctrl_pkg::ACQ_LSB +: 3])
      3'h0: acqLen = 5'h00;
      3'h1: acqLen = 5'h02;
      3'h2: acqLen = 5'h04;
      3'h3: acqLen = 5'h06;
      3'h4: acqLen = 5'h08;
      3'h5: acqLen = 5'h0C;
      3'h6: acqLen = 5'h10;
      default: acqLen = 5'h14;
    endcase
  end

  // reserved codes fall back to supply and ground
  always_comb begin
    case (trigRef_q[adc_ctrl_pkg::PREF_LSB +: 2])
      2'h1: posRefSel = adc_ctrl_pkg::PREF_PIN;
      2'h2: posRefSel = adc_ctrl_pkg::PREF_FIXED;
      default: posRefSel = adc_ctrl_pkg::PREF_SUPPLY;
    endcase
    negRefSel = (trigRef_q[1:0] == 2'h1) ? adc_ctrl_pkg::NREF_PIN
                                         : adc_ctrl_pkg::NREF_GROUND;
  end

  // trigger selection and gating
  assign trigger_source_select = trigRef_q[adc_ctrl_pkg::TRIG_SEL_BIT];
  assign trigEv = enable_q && (trigger_source_select ? chargeTimeTrig : captureFiveTrig);

  // ----------------------------------------------------------------
  // conversion sequencer
  // ----------------------------------------------------------------
  assign doneEv = (state_q == S_CONV) && tadTick
                  && (tadCnt_q == 5'(adc_ctrl_pkg::CONV_TAD - 1));

  // a start while busy before the last conversion cycle is ignored, the start bit already reads one; a later one runs after the gap
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_q <= S_IDLE;
      tadCnt_q <= 5'h00;
      instCnt_q <= 6'h00;
    end else begin
      case (state_q)
        S_IDLE: begin
          tadCnt_q <= 5'h00;
          instCnt_q <= 6'h00;
          if (start_q) begin
            state_q <= S_ACQ;
          end
        end
        S_ACQ: begin
          if (acqLen == 5'h00 || (tadTick && tadCnt_q == acqLen - 5'h01)) begin
            state_q <= useOsc ? S_DELAY : S_CONV;
            tadCnt_q <= 5'h00;
          end else if (tadTick) begin
            tadCnt_q <= tadCnt_q + 5'h01;
          end
        end
        S_DELAY: begin
          instCnt_q <= instCnt_q + 6'h01;
          if (instCnt_q == 6'(adc_ctrl_pkg::INSTR_CYC - 1)) begin
            state_q <= S_CONV;
          end
        end
        S_CONV: begin
          if (doneEv) begin
            state_q <= S_GAP;
            tadCnt_q <= 5'h00;
          end else if (tadTick) begin
            tadCnt_q <= tadCnt_q + 5'h01;
          end
        end
        S_GAP: begin
          if (tadTick && tadCnt_q == 5'(adc_ctrl_pkg::GAP_TAD - 1)) begin
            state_q <= S_IDLE;
          end else if (tadTick) begin
            tadCnt_q <= tadCnt_q + 5'h01;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  assign holdCapConnect = (state_q == S_ACQ) || (state_q == S_DELAY);
  assign convActive = state_q == S_CONV;

  // ----------------------------------------------------------------
  // AXI4-Lite write side
  // ----------------------------------------------------------------
  assign s_axi_awready = !awPend_q && !s_axi_bvalid;
  assign s_axi_wready = !wPend_q && !s_axi_bvalid;
  assign wrHit = awPend_q && wPend_q;
  assign s_axi_bresp = 2'h0;

  // hold address and data until both have arrived
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      awPend_q <= 1'b0;
      wPend_q <= 1'b0;
      awAddr_q <= 8'h00;
      wData_q <= 32'h0000_0000;
      wStrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awPend_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wPend_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      if (wrHit) begin
        awPend_q <= 1'b0;
        wPend_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // control registers; reserved bits are never stored
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      trigRef_q <= adc_ctrl_pkg::TRIG_REF_RST;
      fmtTim_q <= adc_ctrl_pkg::FMT_TIM_RST;
      enable_q <= 1'b0;
      irqMask_q <= 2'h0;
    end else if (wrHit && wStrb_q[0]) begin
      case (awAddr_q)
        adc_ctrl_pkg::OFF_TRIG_REF: trigRef_q <= wData_q[7:0] & adc_ctrl_pkg::TRIG_REF_WMASK;
        adc_ctrl_pkg::OFF_FMT_TIM: fmtTim_q <= wData_q[7:0] & adc_ctrl_pkg::FMT_TIM_WMASK;
        adc_ctrl_pkg::OFF_CTRL: enable_q <= wData_q[adc_ctrl_pkg::ENABLE_BIT];
        adc_ctrl_pkg::OFF_IRQ_MASK: irqMask_q <= wData_q[1:0];
        default: ;
      endcase
    end
  end

  // start bit: set by software or trigger, cleared by hardware at the end
  assign swStart = wrHit && wStrb_q[0] && (awAddr_q == adc_ctrl_pkg::OFF_CTRL)
                   && wData_q[adc_ctrl_pkg::START_BIT] && wData_q[adc_ctrl_pkg::ENABLE_BIT];
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      start_q <= 1'b0;
    end else if (swStart || trigEv) begin
      start_q <= 1'b1;
    end else if (doneEv) begin
      start_q <= 1'b0;
    end
  end

  // result bytes: software may overwrite, conversion end wins; no reset value
  always_ff @(posedge clock) begin
    if (doneEv) begin
      if (fmtTim_q[adc_ctrl_pkg::JUSTIFY_BIT]) begin
        resHi_q <= {6'h00, sarResult[9:8]};
        resLo_q <= sarResult[7:0];
      end else begin
        resHi_q <= sarResult[9:2];
        resLo_q <= {sarResult[1:0], 6'h00};
      end
    end else if (wrHit && wStrb_q[0] && awAddr_q == adc_ctrl_pkg::OFF_RES_HI) begin
      resHi_q <= wData_q[7:0];
    end else if (wrHit && wStrb_q[0] && awAddr_q == adc_ctrl_pkg::OFF_RES_LO) begin
      resLo_q <= wData_q[7:0];
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read side and interrupts
  // ----------------------------------------------------------------
  always_comb begin
    case (s_axi_araddr)
      adc_ctrl_pkg::OFF_TRIG_REF: rdVal = {24'h000000, trigRef_q};
      adc_ctrl_pkg::OFF_FMT_TIM: rdVal = {24'h000000, fmtTim_q};
      adc_ctrl_pkg::OFF_RES_HI: rdVal = {24'h000000, resHi_q};
      adc_ctrl_pkg::OFF_RES_LO: rdVal = {24'h000000, resLo_q};
      adc_ctrl_pkg::OFF_CTRL: rdVal = {30'h0, start_q, enable_q};
      adc_ctrl_pkg::OFF_IRQ_STAT: rdVal = {30'h0, irqStat_q};
      adc_ctrl_pkg::OFF_IRQ_MASK: rdVal = {30'h0, irqMask_q};
      default: rdVal = 32'h0000_0000;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  // unmapped reads answer zero with an error response
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdVal;
      s_axi_rresp <= (s_axi_araddr > adc_ctrl_pkg::OFF_IRQ_MASK || s_axi_araddr[1:0] != 2'h0)
                     ? 2'h2 : 2'h0;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // sticky events; a new event in the read cycle survives the clear
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      irqStat_q <= 2'h0;
    end else begin
      if (s_axi_arvalid && s_axi_arready && s_axi_araddr == adc_ctrl_pkg::OFF_IRQ_STAT) begin
        irqStat_q <= {trigEv, doneEv};
      end else begin
        irqStat_q <= irqStat_q | {trigEv, doneEv};
      end
    end
  end

  assign irq = |(irqStat_q & irqMask_q);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence seqStart;
    $rose(start_q);
  endsequence

  a_trigger_ignored_off: assert property (@(posedge clock) disable iff (!nrst)
    (!enable_q && !swStart) |=> !$rose(start_q)) else $error("trigger while disabled");
  a_start_clears_done: assert property (@(posedge clock) disable iff (!nrst)
    doneEv && !trigEv && !swStart |=> !start_q) else $error("start bit not cleared");
  a_start_begins_acq: assert property (@(posedge clock) disable iff (!nrst)
    seqStart and state_q == S_IDLE |=> state_q == S_ACQ) else $error("no acquisition");
  a_hold_during_acq: assert property (@(posedge clock) disable iff (!nrst)
    holdCapConnect |-> start_q && !convActive) else $error("hold cap outside acquisition");
  a_zero_acq_skip: assert property (@(posedge clock) disable iff (!nrst)
    state_q == S_ACQ && acqLen == 5'h00 |=> state_q != S_ACQ) else $error("zero acq waited");
  a_osc_delay_used: assert property (@(posedge clock) disable iff (!nrst)
    $rose(convActive) |-> $past(instCnt_q)
      == (useOsc ? 6'(adc_ctrl_pkg::INSTR_CYC - 1) : 6'h00))
    else $error("oscillator delay wrong");
  a_right_justify: assert property (@(posedge clock) disable iff (!nrst)
    doneEv && fmtTim_q[7] |=> resLo_q == $past(sarResult[7:0]) && resHi_q[7:2] == 6'h00)
    else $error("right justify wrong");
  a_left_justify: assert property (@(posedge clock) disable iff (!nrst)
    doneEv && !fmtTim_q[7] |=> resHi_q == $past(sarResult[9:2]) && resLo_q[5:0] == 6'h00)
    else $error("left justify wrong");
  a_reserved_read_zero: assert property (@(posedge clock) disable iff (!nrst)
    trigRef_q[6:4] == 3'h0 && fmtTim_q[6] == 1'b0) else $error("reserved bit set");
  a_gap_after_conv: assert property (@(posedge clock) disable iff (!nrst)
    doneEv |=> state_q == S_GAP [*2]) else $error("gap too short");

endmodule : adc_config_and_result_regs

// ==== testbench/tb_top.sv ====
// tb_top: self-checking bench for the adc control and result register block
// assumes adc_ctrl_pkg is compiled first; the bench drives every input port of the block itself
`timescale 1ns/1ps
module tb_top;
  logic clock, nrst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, negRefSel, irq;
  logic chargeTimeTrig, captureFiveTrig, holdCapConnect, convActive;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd, rdb;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rsp, posRefSel;
  logic [9:0] sarResult;
  int error_cnt, checks, hcnt, ccnt;
  int acqTab[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
  int divTab[8] = '{2, 8, 32, adc_ctrl_pkg::INTOSC_DIV, 4, 16, 64, adc_ctrl_pkg::INTOSC_DIV};

  adc_config_and_result_regs dut (
    .clock(clock), .nrst(nrst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .chargeTimeTrig(chargeTimeTrig), .captureFiveTrig(captureFiveTrig),
    .sarResult(sarResult), .holdCapConnect(holdCapConnect), .convActive(convActive),
    .posRefSel(posRefSel), .negRefSel(negRefSel), .irq(irq)
  );

  // ----------------------------------------------------------------
  // clock, phase counters and watchdog
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // counted on the falling edge so the phase lengths never race the design
  always @(negedge clock) begin
    hcnt += int'(holdCapConnect === 1'b1);
    ccnt += int'(convActive === 1'b1);
  end

  // longest run is a few oscillator conversions, far below this span
  initial begin
    repeat (60000) @(posedge clock);
    error_cnt++;
    end_sim();
  end

  // ----------------------------------------------------------------
  // compare, bus and verdict tasks
  // ----------------------------------------------------------------
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  // phase lengths depend on where the divider tick falls, so allow one period plus two clocks
  task automatic cmpNear(input int got, input int exp, input int tol);
    checks++;
    if (got < exp - tol || got > exp + tol) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmpNear

  // handshakes decided at the falling edge, released by nba at the next rising edge
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    bit ah, wh, done;
    int n;
    logic [1:0] br;
    done = 0;
    n = 0;
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done && n < 200) begin
      @(negedge clock);
      ah = awvalid && awready;
      wh = wvalid && wready;
      done = bvalid;
      br = bresp;
      @(posedge clock);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
      if (done) bready <= 1'b0;
      n++;
    end
    if (!done) error_cnt++;
    cmp(32'(br), 32'h0);
  endtask : axw

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    bit ah, done;
    int n;
    done = 0;
    n = 0;
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done && n < 200) begin
      @(negedge clock);
      ah = arvalid && arready;
      done = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clock);
      if (ah) arvalid <= 1'b0;
      if (done) rready <= 1'b0;
      n++;
    end
    if (!done) error_cnt++;
  endtask : axr

  task automatic end_sim;
    if (error_cnt == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_sim

  // ----------------------------------------------------------------
  // conversion and trigger scenarios
  // ----------------------------------------------------------------
  function automatic int expHold(input logic [2:0] cs, input logic [2:0] aq);
    return acqTab[aq] * divTab[cs] + ((cs[1:0] == 2'h3) ? adc_ctrl_pkg::INSTR_CYC : 0);
  endfunction : expHold

  // software start with enable, then phase lengths, busy bit, result layout, irq
  task automatic runConv(input logic [2:0] cs, input logic [2:0] aq, input logic just);
    logic [9:0] res;
    logic [31:0] hi, lo;
    int n;
    res = 10'($urandom);
    n = 0;
    sarResult <= res;
    axw(adc_ctrl_pkg::OFF_FMT_TIM, {24'h0, just, 1'b0, aq, cs});
    hcnt = 0;
    ccnt = 0;
    // with no automatic acquisition, software gives the channel time itself
    if (aq == 3'h0) repeat (20) @(posedge clock);
    axw(adc_ctrl_pkg::OFF_CTRL, 32'h3);
    axr(adc_ctrl_pkg::OFF_CTRL, rd, rsp);
    cmp(rd & 32'h2, 32'h2);
    while (!(ccnt > 0 && !convActive && !holdCapConnect) && n < 30000) begin
      @(negedge clock);
      n++;
    end
    if (n >= 30000) error_cnt++;
    cmpNear(hcnt, expHold(cs, aq), divTab[cs] + 2);
    cmpNear(ccnt, adc_ctrl_pkg::CONV_TAD * divTab[cs], divTab[cs] + 2);
    repeat (2) @(negedge clock);
    cmp(32'(irq), 32'h1);
    axr(adc_ctrl_pkg::OFF_CTRL, rd, rsp);
    cmp(rd & 32'h2, 32'h0);
    axr(adc_ctrl_pkg::OFF_RES_HI, hi, rsp);
    axr(adc_ctrl_pkg::OFF_RES_LO, lo, rsp);
    if (just) begin
      cmp(hi & 32'h3, 32'(res[9:8]));
      cmp(lo & 32'hFF, 32'(res[7:0]));
    end else begin
      cmp(hi & 32'hFF, 32'(res[9:2]));
      cmp(lo & 32'hC0, {24'h0, res[1:0], 6'h0});
    end
    axr(adc_ctrl_pkg::OFF_IRQ_STAT, rd, rsp);
    cmp(rd & 32'h1, 32'h1);
    @(negedge clock);
    cmp(32'(irq), 32'h0);
  endtask : runConv

  // one pulse on either trigger line, then whether acquisition began
  task automatic trigTry(input bit five, input logic expStart);
    logic rose;
    rose = 1'b0;
    @(posedge clock);
    if (five) captureFiveTrig <= 1'b1;
    else chargeTimeTrig <= 1'b1;
    @(posedge clock);
    captureFiveTrig <= 1'b0;
    chargeTimeTrig <= 1'b0;
    repeat (40) begin
      @(negedge clock);
      rose = rose | holdCapConnect | convActive;
    end
    cmp(32'(rose), 32'(expStart));
    repeat (200) @(posedge clock);
  endtask : trigTry

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {nrst, awvalid, wvalid, bready, arvalid, rready} = '0;
    {chargeTimeTrig, captureFiveTrig} = '0;
    {awaddr, araddr, wdata, wstrb, sarResult} = '0;
    {error_cnt, checks, hcnt, ccnt} = '0;
    void'($urandom(32'h6c06));
    repeat (20) @(posedge clock);
    nrst <= 1'b1;
    axr(adc_ctrl_pkg::OFF_TRIG_REF, rd, rsp);
    cmp(rd, 32'h0);
    axr(adc_ctrl_pkg::OFF_FMT_TIM, rd, rsp);
    cmp(rd, 32'h0);
    axw(adc_ctrl_pkg::OFF_TRIG_REF, 32'hFF);
    axr(adc_ctrl_pkg::OFF_TRIG_REF, rd, rsp);
    cmp(rd, 32'h8F);
    axw(adc_ctrl_pkg::OFF_FMT_TIM, 32'hFF);
    axr(adc_ctrl_pkg::OFF_FMT_TIM, rd, rsp);
    cmp(rd, 32'hBF);
    // every reference code pair, the reserved ones included
    for (int i = 0; i < 16; i++) begin
      axw(adc_ctrl_pkg::OFF_TRIG_REF, 32'(i));
      @(negedge clock);
      cmp(32'(posRefSel), (i[3:2] == 2'h3) ? 32'h0 : 32'(i[3:2]));
      cmp(32'(negRefSel), 32'(i[1:0] == 2'h1));
    end
    axr(8'h1C, rd, rsp);
    cmp({rd[31:2], rsp}, 32'h2);
    rd = 32'($urandom_range(0, 255));
    axw(adc_ctrl_pkg::OFF_RES_HI, rd);
    axr(adc_ctrl_pkg::OFF_RES_HI, rdb, rsp);
    cmp(rdb, rd);
    axw(adc_ctrl_pkg::OFF_IRQ_MASK, 32'h1);
    runConv(3'h0, 3'($urandom_range(0, 7)), 1'b0);
    runConv(3'h4, 3'h0, 1'b1);
    runConv(3'h1, 3'h7, 1'($urandom));
    runConv(3'h5, 3'h5, 1'b0);
    runConv(3'h7, 3'h1, 1'b1);
    runConv(3'h3, 3'h0, 1'b0);
    // special triggers: short timing, irq masked off
    axw(adc_ctrl_pkg::OFF_IRQ_MASK, 32'h0);
    axw(adc_ctrl_pkg::OFF_FMT_TIM, 32'h08);
    axw(adc_ctrl_pkg::OFF_CTRL, 32'h0);
    axw(adc_ctrl_pkg::OFF_TRIG_REF, 32'h00);
    trigTry(1'b1, 1'b0);
    axw(adc_ctrl_pkg::OFF_CTRL, 32'h1);
    trigTry(1'b0, 1'b0);
    trigTry(1'b1, 1'b1);
    axw(adc_ctrl_pkg::OFF_TRIG_REF, 32'h80);
    trigTry(1'b1, 1'b0);
    trigTry(1'b0, 1'b1);
    cmp(32'(irq), 32'h0);
    axr(adc_ctrl_pkg::OFF_IRQ_STAT, rd, rsp);
    cmp(rd & 32'h3, 32'h3);
    end_sim();
  end
endmodule : tb_top
